// file: src/dcm_pkg.sv
// constants, types and field layouts of the dual channel mode timer
package dcm_pkg;

	// port map, one counter port and one control/status port per channel
	localparam logic [7:0]  ADDR_CH0_CNT  = 8'h28;
	localparam logic [7:0]  ADDR_CH0_CTL  = 8'h29;
	localparam logic [7:0]  ADDR_CH1_CNT  = 8'h2a;
	localparam logic [7:0]  ADDR_CH1_CTL  = 8'h2b;
	localparam logic [7:0]  ADDR_CH_STEP  = 8'h02;

	// control word layout
	localparam int          CW_KIND_HI    = 5;
	localparam int          CW_KIND_LO    = 3;
	localparam logic [2:0]  CW_CMD_CODE   = 3'h7;
	localparam int          CW_MODE_HI    = 4;
	localparam int          CW_MODE_LO    = 3;
	localparam int          CW_CLKSYS     = 2;
	localparam int          CW_SEQCLR     = 1;
	localparam int          CW_FLAGCLR    = 0;
	localparam logic [1:0]  CW_LATCH_CODE = 2'h0;
	localparam int          CW_OPT_HI     = 7;
	localparam int          CW_OPT_LO     = 6;
	localparam int          CW_OPT0       = 0;

	// mode field codes
	localparam logic [1:0]  MC_FDIV       = 2'h0;
	localparam logic [1:0]  MC_PWM        = 2'h1;
	localparam logic [1:0]  MC_PULSE      = 2'h2;
	localparam logic [1:0]  MC_MEAS       = 2'h3;

	// status layout
	localparam int          ST_MEAS       = 7;
	localparam int          ST_OUT        = 6;
	localparam int          ST_TRIG       = 5;
	localparam int          ST_CLK        = 4;
	localparam int          ST_MODE_LO    = 2;

	// reset and mode-set values
	localparam logic [15:0] CNT_RESET     = 16'hffff;
	localparam logic [7:0]  CFG_RESET     = 8'h04;
	localparam logic [15:0] PWM_MASK_N6   = 16'h003f;
	localparam logic [15:0] PWM_MASK_N8   = 16'h00ff;
	localparam logic [15:0] PWM_MASK_N10  = 16'h03ff;
	localparam logic [15:0] PWM_MASK_N12  = 16'h0fff;

	typedef enum logic [3:0] {
		DCM_FDIV  = 4'b0001,
		DCM_PWM   = 4'b0010,
		DCM_PULSE = 4'b0100,
		DCM_MEAS  = 4'b1000
	} dcm_mode_e;

	// internal i/o bus request, strobes are one-cycle pulses
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} dcm_io_req_s;

	typedef struct packed {
		logic        prev;
	} dcm_edge_s;

	typedef struct packed {
		logic [7:0]  rdata;
	} dcm_rd_s;

	typedef struct packed {
		dcm_mode_e   mode;
		logic [7:0]  cfg;
		logic        set;
		logic        started;
		logic        load_pend;
		logic        active;
		logic        phase_hi;
		logic        armed;
		logic        halted;
		logic [15:0] cnt;
		logic [15:0] reload;
		logic [15:0] latch;
		logic [7:0]  wbyte;
		logic        wr_hi;
		logic        rd_hi;
		logic        out;
		logic        strb;
		logic        trig_flag;
		logic        meas_flag;
	} dcm_chan_s;

endpackage : dcm_pkg

// file: src/dcm_edge.sv
// edge detector for a clock-synchronous input
module dcm_edge #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// sampled level and its edges
	input  wire logic sig,
	output logic      rise,
	output logic      fall
);

	dcm_pkg::dcm_edge_s q;
	dcm_pkg::dcm_edge_s d;

	always_comb begin
		d      = q;
		d.prev = sig;
		rise   = sig & ~q.prev;
		fall   = ~sig & q.prev;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.prev <= RST_VAL;
		end else if (ce) begin
			q <= d;
		end
	end

endmodule : dcm_edge

// file: src/dcm_rdmux.sv
// registered read data multiplexer for the i/o bus
module dcm_rdmux #(
	parameter int NCH = 2
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     ce,
	// per-channel read data and hits
	input  wire logic                     rd,
	input  wire logic [NCH-1:0]           hit,
	input  wire logic [NCH-1:0][7:0]      val,
	// bus read data
	output logic      [7:0]               rdata
);

	dcm_pkg::dcm_rd_s q;
	dcm_pkg::dcm_rd_s d;

	always_comb begin
		d = q;
		if (rd) begin
			// unmapped addresses read as zero
			d.rdata = 8'h00;
			for (int i = 0; i < NCH; i++) begin
				if (hit[i]) begin
					d.rdata = d.rdata | val[i];
				end
			end
		end
		rdata = q.rdata;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.rdata <= 8'h00;
		end else if (ce) begin
			q <= d;
		end
	end

endmodule : dcm_rdmux

// file: src/dcm_timer.sv
// dual channel 16-bit mode timer with i/o port access
module dcm_timer #(
	parameter int NCH = 2
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                ce,
	// internal i/o bus
	input  wire dcm_pkg::dcm_io_req_s io_req,
	output logic      [7:0]          io_rdata,
	// channel pins
	input  wire logic [NCH-1:0]      gate,
	input  wire logic [NCH-1:0]      external_count_clock,
	output logic      [NCH-1:0]      tmr_out
);

	function automatic dcm_pkg::dcm_mode_e mode_of(input logic [1:0] code);
		dcm_pkg::dcm_mode_e m;
		m = dcm_pkg::DCM_FDIV;
		unique case (code)
			dcm_pkg::MC_FDIV:  m = dcm_pkg::DCM_FDIV;
			dcm_pkg::MC_PWM:   m = dcm_pkg::DCM_PWM;
			dcm_pkg::MC_PULSE: m = dcm_pkg::DCM_PULSE;
			dcm_pkg::MC_MEAS:  m = dcm_pkg::DCM_MEAS;
		endcase
		return m;
	endfunction : mode_of

	function automatic logic [1:0] code_of(input dcm_pkg::dcm_mode_e m);
		logic [1:0] c;
		c = dcm_pkg::MC_FDIV;
		unique case (m)
			dcm_pkg::DCM_FDIV:  c = dcm_pkg::MC_FDIV;
			dcm_pkg::DCM_PWM:   c = dcm_pkg::MC_PWM;
			dcm_pkg::DCM_PULSE: c = dcm_pkg::MC_PULSE;
			dcm_pkg::DCM_MEAS:  c = dcm_pkg::MC_MEAS;
		endcase
		return c;
	endfunction : code_of

	function automatic logic [15:0] pwm_mask(input logic [1:0] sel);
		logic [15:0] m;
		m = dcm_pkg::PWM_MASK_N6;
		unique case (sel)
			2'h0: m = dcm_pkg::PWM_MASK_N6;
			2'h1: m = dcm_pkg::PWM_MASK_N8;
			2'h2: m = dcm_pkg::PWM_MASK_N10;
			2'h3: m = dcm_pkg::PWM_MASK_N12;
		endcase
		return m;
	endfunction : pwm_mask

	localparam dcm_pkg::dcm_chan_s CH_RESET = '{
		mode:      dcm_pkg::DCM_FDIV,
		cfg:       dcm_pkg::CFG_RESET,
		set:       1'b0,
		started:   1'b0,
		load_pend: 1'b0,
		active:    1'b0,
		phase_hi:  1'b0,
		armed:     1'b0,
		halted:    1'b0,
		cnt:       dcm_pkg::CNT_RESET,
		reload:    dcm_pkg::CNT_RESET,
		latch:     dcm_pkg::CNT_RESET,
		wbyte:     8'h00,
		wr_hi:     1'b0,
		rd_hi:     1'b0,
		out:       1'b0,
		strb:      1'b0,
		trig_flag: 1'b0,
		meas_flag: 1'b0
	};

	logic [NCH-1:0]      rd_hit;
	logic [NCH-1:0][7:0] rd_val;

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			localparam logic [7:0] A_CNT = 8'(dcm_pkg::ADDR_CH0_CNT
				+ 8'(c) * dcm_pkg::ADDR_CH_STEP);
			localparam logic [7:0] A_CTL = 8'(dcm_pkg::ADDR_CH0_CTL
				+ 8'(c) * dcm_pkg::ADDR_CH_STEP);

			dcm_pkg::dcm_chan_s q;
			dcm_pkg::dcm_chan_s d;
			logic               g_rise;
			logic               g_fall;
			logic               x_fall;

			dcm_edge #(
				.RST_VAL (1'b0)
			) u_gate_edge (
				.clk   (clk),
				.rst_n (rst_n),
				.ce    (ce),
				.sig   (gate[c]),
				.rise  (g_rise),
				.fall  (g_fall)
			);

			dcm_edge #(
				.RST_VAL (1'b0)
			) u_external_count_clock_edge (
				.clk   (clk),
				.rst_n (rst_n),
				.ce    (ce),
				.sig   (external_count_clock[c]),
				.rise  (),
				.fall  (x_fall)
			);

			always_comb begin
				logic        wr_cnt;
				logic        wr_ctl;
				logic        rd_cnt;
				logic        rd_ctl;
				logic        cmd;
				logic        mset;
				logic        tick;
				logic        inv;
				logic        strobe;
				logic        hard;
				logic        s_hit;
				logic        e_hit;
				logic [7:0]  wd;
				logic [7:0]  st;
				wd     = io_req.wdata;
				st     = 8'h00;
				wr_cnt = io_req.wr && (io_req.addr == A_CNT);
				wr_ctl = io_req.wr && (io_req.addr == A_CTL);
				rd_cnt = io_req.rd && (io_req.addr == A_CNT);
				rd_ctl = io_req.rd && (io_req.addr == A_CTL);
				cmd    = wr_ctl && (wd[dcm_pkg::CW_KIND_HI:dcm_pkg::CW_KIND_LO]
					== dcm_pkg::CW_CMD_CODE);
				mset   = wr_ctl && !wd[dcm_pkg::CW_KIND_HI];
				// system clock or falling external edge
				tick   = q.cfg[dcm_pkg::CW_CLKSYS] ? 1'b1 : x_fall;
				inv    = q.cfg[dcm_pkg::CW_OPT0];
				strobe = q.cfg[dcm_pkg::CW_OPT_HI];
				hard   = q.cfg[dcm_pkg::CW_OPT_LO];
				s_hit  = q.cfg[dcm_pkg::CW_OPT_HI] ? g_rise : g_fall;
				e_hit  = q.cfg[dcm_pkg::CW_OPT_LO] ? g_rise : g_fall;
				d      = q;

				// clear first so a same-cycle event wins
				if (cmd && wd[dcm_pkg::CW_FLAGCLR]) begin
					d.trig_flag = 1'b0;
					d.meas_flag = 1'b0;
				end

				// nothing runs until a mode word arrives
				if (q.set) begin
					unique case (q.mode)
						dcm_pkg::DCM_FDIV: begin
							if (tick) begin
								if (q.strb) begin
									d.out  = 1'b0;
									d.strb = 1'b0;
								end
								if (q.load_pend) begin
									d.cnt       = q.reload;
									d.load_pend = 1'b0;
									d.started   = 1'b1;
								end else if (q.started && gate[c]) begin
									if (q.cnt == 16'h0000) begin
										d.cnt = q.reload;
										if (q.cfg[dcm_pkg::CW_OPT_LO]) begin
											d.out  = 1'b1;
											d.strb = 1'b1;
										end else begin
											d.out = ~q.out;
										end
									end else begin
										d.cnt = q.cnt - 16'h0001;
									end
								end
							end
						end
						dcm_pkg::DCM_PWM: begin
							if (tick) begin
								if (q.load_pend) begin
									d.cnt       = q.reload;
									d.out       = 1'b1;
									d.phase_hi  = 1'b1;
									d.load_pend = 1'b0;
									d.started   = 1'b1;
								end else if (q.started && gate[c]) begin
									if (q.cnt == 16'h0000) begin
										if (q.phase_hi) begin
											// low time fills the period to 2^n + 1 ticks
											d.cnt = ~q.reload
												& pwm_mask(q.cfg[dcm_pkg::CW_OPT_HI:
												dcm_pkg::CW_OPT_LO]);
											d.out      = 1'b0;
											d.phase_hi = 1'b0;
										end else begin
											d.cnt      = q.reload;
											d.out      = 1'b1;
											d.phase_hi = 1'b1;
										end
									end else begin
										d.cnt = q.cnt - 16'h0001;
									end
								end
							end
						end
						dcm_pkg::DCM_PULSE: begin
							if (hard && g_rise) begin
								d.load_pend = 1'b1;
								d.trig_flag = 1'b1;
							end
							if (tick) begin
								if (q.strb) begin
									d.out  = ~inv;
									d.strb = 1'b0;
								end
								if (q.load_pend) begin
									d.cnt       = q.reload;
									d.active    = 1'b1;
									d.load_pend = 1'b0;
									if (!strobe) begin
										d.out = inv;
									end
								end else if (q.active && (hard || gate[c])) begin
									if (q.cnt == 16'h0000) begin
										d.cnt    = dcm_pkg::CNT_RESET;
										d.active = 1'b0;
										if (strobe) begin
											d.out  = inv;
											d.strb = 1'b1;
										end else begin
											d.out = ~inv;
										end
									end else begin
										d.cnt = q.cnt - 16'h0001;
									end
								end
							end
						end
						dcm_pkg::DCM_MEAS: begin
							// complete pulse lasts one system clock
							d.out = 1'b0;
							if (!q.halted) begin
								if (q.armed && e_hit) begin
									d.reload    = ~q.cnt;
									d.out       = 1'b1;
									d.meas_flag = 1'b1;
									if (q.cfg[dcm_pkg::CW_OPT0]) begin
										d.cnt   = dcm_pkg::CNT_RESET;
										d.armed = (q.cfg[dcm_pkg::CW_OPT_HI]
											== q.cfg[dcm_pkg::CW_OPT_LO]);
									end else begin
										// single run keeps its last count
										d.halted = 1'b1;
										d.armed  = 1'b0;
									end
								end else if (!q.armed && s_hit) begin
									d.reload = ~q.cnt;
									d.cnt    = dcm_pkg::CNT_RESET;
									d.armed  = 1'b1;
								end else if (q.armed && tick) begin
									d.cnt = q.cnt - 16'h0001;
								end
							end
						end
					endcase
				end

				// two-byte count write, low byte first
				if (wr_cnt && (q.mode != dcm_pkg::DCM_MEAS)) begin
					if (!q.wr_hi) begin
						d.wbyte = wd;
						d.wr_hi = 1'b1;
					end else begin
						d.reload = {wd, q.wbyte};
						d.wr_hi  = 1'b0;
						if (q.mode == dcm_pkg::DCM_PULSE) begin
							if (!hard) begin
								d.load_pend = 1'b1;
								d.trig_flag = 1'b1;
							end
						end else if (!q.started) begin
							d.load_pend = 1'b1;
						end
					end
				end

				// latch readout, low byte then high
				if (rd_cnt) begin
					d.rd_hi = ~q.rd_hi;
				end

				if (cmd) begin
					if (wd[dcm_pkg::CW_SEQCLR:dcm_pkg::CW_FLAGCLR]
						== dcm_pkg::CW_LATCH_CODE) begin
						d.latch = q.cnt;
						d.rd_hi = 1'b0;
					end
					if (wd[dcm_pkg::CW_SEQCLR]) begin
						d.rd_hi = 1'b0;
						d.wr_hi = 1'b0;
					end
				end

				if (mset) begin
					d           = CH_RESET;
					d.latch     = q.latch;
					d.cfg       = wd;
					d.set       = 1'b1;
					d.mode      = mode_of(wd[dcm_pkg::CW_MODE_HI:
						dcm_pkg::CW_MODE_LO]);
					d.wr_hi     = 1'b0;
					d.reload    = dcm_pkg::CNT_RESET;
					d.cnt       = dcm_pkg::CNT_RESET;
					d.out       = 1'b0;
					if (d.mode == dcm_pkg::DCM_PWM) begin
						d.cnt = pwm_mask(wd[dcm_pkg::CW_OPT_HI:
							dcm_pkg::CW_OPT_LO]);
					end
					if (d.mode == dcm_pkg::DCM_PULSE) begin
						d.out = ~wd[dcm_pkg::CW_OPT0];
					end
				end

				st[dcm_pkg::ST_MEAS] = q.meas_flag;
				st[dcm_pkg::ST_OUT]  = q.out;
				st[dcm_pkg::ST_TRIG] = q.trig_flag;
				st[dcm_pkg::ST_CLK]  = q.cfg[dcm_pkg::CW_CLKSYS];
				st[dcm_pkg::ST_MODE_LO +: 2] = code_of(q.mode);
				rd_hit[c] = rd_cnt || rd_ctl;
				rd_val[c] = rd_ctl ? st
					: (q.rd_hi ? q.latch[15:8] : q.latch[7:0]);
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					q <= CH_RESET;
				end else if (ce) begin
					q <= d;
				end
			end

			assign tmr_out[c] = q.out;
		end
	endgenerate

	dcm_rdmux #(
		.NCH (NCH)
	) u_rdmux (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.rd    (io_req.rd),
		.hit   (rd_hit),
		.val   (rd_val),
		.rdata (io_rdata)
	);

endmodule : dcm_timer

// file: verification/dcm_timer_sva.sv
// port assertions of the dual channel mode timer
module dcm_timer_sva #(
	parameter int NCH = 2
) (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 ce,
	// i/o bus
	input wire dcm_pkg::dcm_io_req_s io_req,
	input wire logic [7:0]           io_rdata,
	// channel pins
	input wire logic [NCH-1:0]       gate,
	input wire logic [NCH-1:0]       external_count_clock,
	input wire logic [NCH-1:0]       tmr_out
);
	logic       w0;
	logic       wm;
	logic       a0;
	logic [1:0] mode_q;
	logic       sys_q;
	logic       idle_q;
	logic       g_q;
	logic       x_q;
	logic [2:0] qg_q;
	logic [2:0] qx_q;

	// mode words on channel 0 and on any channel, any channel 0 write
	assign wm = ce && io_req.wr && io_req.wdata[5] == 1'b0
		&& (io_req.addr == 8'h29 || io_req.addr == 8'h2b);
	assign w0 = wm && io_req.addr == dcm_pkg::ADDR_CH0_CTL;
	assign a0 = ce && io_req.wr && io_req.addr[7:1] == 7'h14;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= 2'h0;
			sys_q  <= 1'b1;
			idle_q <= 1'b1;
			g_q    <= 1'b0;
			x_q    <= 1'b1;
			qg_q   <= 3'h0;
			qx_q   <= 3'h0;
		end else begin
			if (w0) begin
				mode_q <= io_req.wdata[4:3];
				sys_q  <= io_req.wdata[2];
			end
			idle_q <= idle_q && !wm;
			g_q    <= gate[0];
			x_q    <= external_count_clock[0];
			qg_q   <= (w0 || gate[0] != g_q) ? 3'h0 : qg_q + {2'h0, qg_q != 3'h7};
			qx_q   <= (a0 || external_count_clock[0] != x_q) ? 3'h0
				: qx_q + {2'h0, qx_q != 3'h7};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_unmapped_zero: assert property (ce && io_req.rd && (io_req.addr < 8'h28
		|| io_req.addr > 8'h2b) |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!(ce && io_req.rd) |=> $stable(io_rdata))
		else $error("read data moved without a read");
	a_status_out: assert property (ce && io_req.rd
		&& io_req.addr == dcm_pkg::ADDR_CH0_CTL
		|=> io_rdata[1:0] == 2'h0 && io_rdata[6] == $past(tmr_out[0]))
		else $error("status byte wrong");
	a_idle_low: assert property (idle_q |-> tmr_out == '0)
		else $error("output left low level before a mode");
	a_meas_pulse: assert property (mode_q == dcm_pkg::MC_MEAS && ce
		&& $rose(tmr_out[0]) |=> !tmr_out[0])
		else $error("measure pulse longer than one clock");
	a_meas_quiet: assert property (mode_q == dcm_pkg::MC_MEAS
		&& qg_q == 3'h7 |-> !tmr_out[0])
		else $error("measure output high without an edge");
	a_ext_hold: assert property (mode_q == dcm_pkg::MC_FDIV && !sys_q
		&& qx_q == 3'h7 && external_count_clock[0] == x_q
		|=> $stable(tmr_out[0]))
		else $error("output moved with external clock still");
	a_gate_hold: assert property (mode_q == dcm_pkg::MC_FDIV && sys_q
		&& !gate[0] && qg_q == 3'h7 |=> $stable(tmr_out[0]))
		else $error("output moved with gate low");
	a_ce_freeze: assert property (!ce |=> $stable(tmr_out)
		&& $stable(io_rdata))
		else $error("state moved with clock enable low");
endmodule : dcm_timer_sva

bind dcm_timer dcm_timer_sva #(.NCH(NCH)) dcm_timer_sva_inst (
	.clk(clk), .rst_n(rst_n), .ce(ce), .io_req(io_req),
	.io_rdata(io_rdata), .gate(gate),
	.external_count_clock(external_count_clock), .tmr_out(tmr_out));

// file: verification/dcm_cpu_model.sv
// cpu core model issuing i/o bus cycles to the timer
module dcm_cpu_model (
	// clock
	input  wire logic           clk,
	// i/o bus
	output dcm_pkg::dcm_io_req_s io_req,
	input  wire logic [7:0]     io_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial io_req = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		io_req <= {1'b1, 1'b0, a, d};
		@(posedge clk);
		io_req <= '0;
	endtask : wr

	// data lands one cycle after the strobe is taken
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		io_req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		io_req <= '0;
		@(posedge clk);
		d = io_rdata;
	endtask : rd

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a, v[15:8]);
	endtask : wr16

	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a, v[15:8]);
	endtask : rd16
endmodule : dcm_cpu_model

// file: verification/testbench.sv
// self-checking bench of the dual channel mode timer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       ch;
		logic [7:0] cw;
		logic [7:0] st;
	} dcm_row_s;

	localparam logic [7:0] C0 = dcm_pkg::ADDR_CH0_CTL;
	localparam logic [7:0] C1 = dcm_pkg::ADDR_CH1_CTL;
	localparam logic [7:0] N0 = dcm_pkg::ADDR_CH0_CNT;
	localparam logic [7:0] N1 = dcm_pkg::ADDR_CH1_CNT;

	logic                 clk;
	logic                 rst_n;
	logic                 ce;
	dcm_pkg::dcm_io_req_s io_req;
	logic [7:0]           io_rdata;
	logic [1:0]           gate;
	logic [1:0]           ext_clk;
	logic [1:0]           tmr_out;
	logic [7:0]           a;
	logic [7:0]           b;
	logic [15:0]          w;
	logic                 o;
	int                   k;
	int                   n_fail;
	int                   checked;
	// mode word per channel and the status it should read back
	dcm_row_s rows [6] = '{{1'b0, 8'h04, 8'h10}, {1'b1, 8'h40, 8'h00},
		{1'b0, 8'h0c, 8'h14}, {1'b1, 8'h94, 8'h58},
		{1'b0, 8'h15, 8'h18}, {1'b1, 8'hdd, 8'h1c}};

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	dcm_timer #(.NCH(2)) dcm_timer_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
		.io_req(io_req), .io_rdata(io_rdata), .gate(gate),
		.external_count_clock(ext_clk), .tmr_out(tmr_out));
	dcm_cpu_model dcm_cpu_model_inst (.clk(clk), .io_req(io_req),
		.io_rdata(io_rdata));

	task automatic results();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// cycles until the output shows level v
	task automatic wait_out(input int c, input logic v, output int n);
		n = 0;
		while (tmr_out[c] !== v && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) begin
			n_fail++;
			$display("[FAIL] %0t out %h exp %h", $time, tmr_out[c], v);
			results();
		end
	endtask : wait_out

	task automatic ext_fall();
		ext_clk[0] <= 1'b0;
		repeat (2) @(posedge clk);
		ext_clk[0] <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : ext_fall

	initial begin
		rst_n   = 1'b0;
		ce      = 1'b1;
		gate    = 2'h0;
		ext_clk = 2'h3;
		n_fail  = 0;
		checked = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		dcm_cpu_model_inst.rd(C0, b);
		chk(b, 16'h0010);
		dcm_cpu_model_inst.wr(C0, 8'h38);
		dcm_cpu_model_inst.rd16(N0, w);
		chk(w, 16'hffff);
		dcm_cpu_model_inst.wr(8'h2c, 8'h5a);
		dcm_cpu_model_inst.rd(8'h2c, b);
		chk(b, 16'h0000);
		$display("test reset done");
		foreach (rows[i]) begin
			a = C0 + {6'h00, rows[i].ch, 1'b0};
			dcm_cpu_model_inst.wr(a, rows[i].cw);
			dcm_cpu_model_inst.rd(a, b);
			chk(b, rows[i].st);
			chk(tmr_out[rows[i].ch], rows[i].st[6]);
		end
		$display("test mode rows done");
		// divide by 5 toggle, then a new count takes effect at zero
		dcm_cpu_model_inst.wr(C0, 8'h04);
		gate[0] <= 1'b1;
		dcm_cpu_model_inst.wr16(N0, 16'h0004);
		wait_out(0, 1'b1, k);
		wait_out(0, 1'b0, k);
		chk(k, 16'h0005);
		dcm_cpu_model_inst.wr16(N0, 16'h0002);
		// the old count may still run one period after the write
		wait_out(0, 1'b1, k);
		wait_out(0, 1'b0, k);
		wait_out(0, 1'b1, k);
		chk(k, 16'h0003);
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		gate[0] <= 1'b0;
		repeat (3) @(posedge clk);
		o = tmr_out[0];
		repeat (20) @(posedge clk);
		chk(tmr_out[0], o);
		$display("test divide done");
		dcm_cpu_model_inst.wr(C1, 8'h0c);
		gate[1] <= 1'b1;
		dcm_cpu_model_inst.wr16(N1, 16'h0010);
		wait_out(1, 1'b1, k);
		wait_out(1, 1'b0, k);
		chk(k, 16'h0011);
		wait_out(1, 1'b1, k);
		chk(k, 16'h0030);
		gate[1] <= 1'b0;
		// period 2^12 + 1, latch with don't-care bits, then sequence clears
		dcm_cpu_model_inst.wr(C1, 8'hcc);
		dcm_cpu_model_inst.wr(C1, 8'hfc);
		dcm_cpu_model_inst.rd(N1, b);
		chk(b, 16'h00ff);
		dcm_cpu_model_inst.wr(C1, 8'h3a);
		dcm_cpu_model_inst.rd16(N1, w);
		chk(w, 16'h0fff);
		dcm_cpu_model_inst.wr(N1, 8'h05);
		dcm_cpu_model_inst.wr(C1, 8'h3a);
		gate[1] <= 1'b1;
		dcm_cpu_model_inst.wr16(N1, 16'h0003);
		wait_out(1, 1'b1, k);
		wait_out(1, 1'b0, k);
		chk(k, 16'h0004);
		gate[1] <= 1'b0;
		$display("test pwm done");
		dcm_cpu_model_inst.wr(C0, 8'h14);
		gate[0] <= 1'b1;
		dcm_cpu_model_inst.wr16(N0, 16'h0005);
		wait_out(0, 1'b0, k);
		wait_out(0, 1'b1, k);
		dcm_cpu_model_inst.rd(C0, b);
		chk(b, 16'h0078);
		dcm_cpu_model_inst.wr(C0, 8'h38);
		dcm_cpu_model_inst.rd16(N0, w);
		chk(w, 16'hffff);
		dcm_cpu_model_inst.wr(C0, 8'h39);
		dcm_cpu_model_inst.rd(C0, b);
		chk(b, 16'h0058);
		gate[0] <= 1'b0;
		dcm_cpu_model_inst.wr(C0, 8'h54);
		dcm_cpu_model_inst.wr16(N0, 16'h0003);
		repeat (8) @(posedge clk);
		chk(tmr_out[0], 1'b1);
		gate[0] <= 1'b1;
		wait_out(0, 1'b0, k);
		wait_out(0, 1'b1, k);
		$display("test pulse done");
		gate[0] <= 1'b0;
		dcm_cpu_model_inst.wr(C0, 8'hdd);
		repeat (4) @(posedge clk);
		gate[0] <= 1'b1;
		repeat (10) @(posedge clk);
		chk(tmr_out[0], 1'b0);
		gate[0] <= 1'b0;
		repeat (10) @(posedge clk);
		gate[0] <= 1'b1;
		wait_out(0, 1'b1, k);
		dcm_cpu_model_inst.rd(C0, b);
		chk(b, 16'h009c);
		dcm_cpu_model_inst.wr(C0, 8'h39);
		dcm_cpu_model_inst.rd(C0, b);
		chk(b, 16'h001c);
		$display("test measure done");
		// single falling-to-falling measurement holds its count
		dcm_cpu_model_inst.wr(C0, 8'h1c);
		repeat (4) @(posedge clk);
		gate[0] <= 1'b0;
		repeat (5) @(posedge clk);
		gate[0] <= 1'b1;
		repeat (5) @(posedge clk);
		gate[0] <= 1'b0;
		repeat (10) @(posedge clk);
		dcm_cpu_model_inst.wr(C0, 8'h38);
		dcm_cpu_model_inst.rd16(N0, w);
		chk(w, 16'hfff6);
		$display("test single measure done");
		dcm_cpu_model_inst.wr(C0, 8'h00);
		gate[0] <= 1'b1;
		dcm_cpu_model_inst.wr16(N0, 16'h0002);
		for (int j = 0; j < 2; j++) begin
			o = tmr_out[0];
			k = 0;
			while (tmr_out[0] === o && k < 20) begin
				ext_fall();
				k++;
			end
			if (k >= 20) begin
				chk(tmr_out[0], ~o);
				results();
			end
		end
		chk(k, 16'h0003);
		repeat (20) @(posedge clk);
		$display("test external clock done");
		// divide pulse output, then inverted strobe pulse
		dcm_cpu_model_inst.wr(C1, 8'h44);
		gate[1] <= 1'b1;
		dcm_cpu_model_inst.wr16(N1, 16'h0002);
		wait_out(1, 1'b1, k);
		wait_out(1, 1'b0, k);
		chk(k, 16'h0001);
		wait_out(1, 1'b1, k);
		chk(k, 16'h0002);
		dcm_cpu_model_inst.wr(C1, 8'h95);
		dcm_cpu_model_inst.wr16(N1, 16'h0002);
		wait_out(1, 1'b1, k);
		wait_out(1, 1'b0, k);
		chk(k, 16'h0001);
		$display("test output options done");
		// reset in mid-run stops both channels again
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk(tmr_out, 16'h0000);
		dcm_cpu_model_inst.rd(C1, b);
		chk(b, 16'h0010);
		dcm_cpu_model_inst.wr(C1, 8'h38);
		dcm_cpu_model_inst.rd16(N1, w);
		chk(w, 16'hffff);
		$display("test second reset done");
		results();
	end
endmodule : testbench
